// ---- core/rx_irq_defines.vh ----
// Register offsets, field positions and reset values of the receiver interrupt mask and mode block.
// Assumes register port addresses are 7-bit, as used by the device control port.
`ifndef RX_IRQ_DEFINES_VH
`define RX_IRQ_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define RX_IRQ_ENABLE_ONE_ADDR   7'h16
`define RX_IRQ_ENABLE_TWO_ADDR   7'h17
`define RX_IRQ_TRIGGER_ONE_ADDR  7'h18

// ****************************************
// Reset values
// ****************************************
`define RX_IRQ_ENABLE_ONE_RST    8'h00
`define RX_IRQ_ENABLE_TWO_RST    8'h00
`define RX_IRQ_TRIGGER_ONE_RST   8'h00
`define RX_IRQ_TWO_MASK          8'h01

// ****************************************
// Enable register one fields, then the output slip bit of enable register two
// ****************************************
`define CS_CRC_BIT               7
`define PARITY_ERR_BIT           6
`define VALIDITY_BIT             5
`define BIPHASE_ERR_BIT          4
`define SUBCODE_CHANGE_BIT       3
`define LOCK_LOSS_BIT            2
`define SUBCODE_CRC_BIT          1
`define BUFFER_XFER_BIT          0
`define OUT_SLIP_BIT             0

// ****************************************
// Mode register one field positions
// ****************************************
`define SUBCODE_CHANGE_TRIG_LSB  6
`define LOCK_LOSS_TRIG_LSB       4
`define SUBCODE_CRC_TRIG_LSB     2
`define BUFFER_XFER_TRIG_LSB     0

// ****************************************
// Trigger mode encodings
// ****************************************
`define TRIG_RISE                2'h0
`define TRIG_FALL                2'h1
`define TRIG_LEVEL               2'h2
`define TRIG_RSVD                2'h3

`endif

// ---- core/flag_trigger.v ----
// One flag's trigger detector: rising edge, falling edge or level.
// Assumes the flag input is synchronous to the clock and reset is already synchronised.
`timescale 1ns/10ps
`include "rx_irq_defines.vh"

module flag_trigger (
	// Clock and reset
	input  wire       clk_in,
	input  wire       rst_b_in,
	// Flag and controls
	input  wire       flag_in,
	input  wire       enable_in,
	input  wire [1:0] mode_in,
	// Request
	output wire       req_out
);

	reg flag_d_r;
	reg hit;

	// Previous flag level for edge detection
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flag_d_r <= 1'b0;
		end else begin
			flag_d_r <= flag_in;
		end
	end

	// Mode decode; the reserved code raises nothing
	always @* begin
		case (mode_in)
			`TRIG_RISE: begin
				hit = flag_in & ~flag_d_r;
			end
			`TRIG_FALL: begin
				hit = ~flag_in & flag_d_r;
			end
			`TRIG_LEVEL: begin
				hit = flag_in;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Enable gates only the request, never the flag history
	assign req_out = hit & enable_in;

endmodule // flag_trigger

// ---- core/receiver_irq_mask_mode.v ----
// Receiver interrupt mask and trigger mode registers with the combined active-low interrupt.
// Assumes a simple synchronous register port from the serial control interface and
// flag inputs that are synchronous to core_clk_in.
//
// Contract
// - CRC error enable bit masks that flag at 0 (reset), passes it at 1.
// - Parity error enable bit masks at 0 (reset), passes at 1.
// - Validity enable bit masks at 0 (reset), passes at 1.
// - Biphase coding error enable masks at 0 (reset), passes at 1.
// - Enable register one holds eight bits, CRC at bit 7 down to buffer transfer.
// - Mode field: 00 rising (reset), 01 falling, 10 level, 11 reserved.
// - Flag interrupts only when enabled in 0x16; status itself is unaffected.
// - Output slip interrupts only when bit 0 of 0x17 set; others read zero.
// - Combined receiver interrupt is an active-low output for a GPO pin.
`timescale 1ns/10ps
`include "rx_irq_defines.vh"

module receiver_irq_mask_mode (
	// Clock and reset
	input  wire       core_clk_in,
	input  wire       rst_b_in,
	// Register port
	input  wire [6:0] reg_addr_in,
	input  wire [7:0] reg_wdata_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	output reg  [7:0] reg_rdata_out,
	output wire       reg_hit_out,
	// Receiver status flags, bit 7 to 0 as in enable register one, then output slip
	input  wire       cs_crc_error_flag_in,
	input  wire       parity_err_flag_in,
	input  wire       validity_flag_in,
	input  wire       biphase_error_flag_in,
	input  wire       subcode_change_flag_in,
	input  wire       lock_loss_flag_in,
	input  wire       subcode_crc_flag_in,
	input  wire       buffer_xfer_flag_in,
	input  wire       out_slip_flag_in,
	// Modes of the flags held outside this block
	input  wire [1:0] cs_crc_trigger_in,
	input  wire [1:0] parity_err_trigger_in,
	input  wire [1:0] validity_trigger_in,
	input  wire [1:0] biphase_err_trigger_in,
	input  wire [1:0] out_slip_trigger_in,
	// Interrupt
	output reg        rx_irq_b_out
);

	// ****************************************
	// Reset synchroniser
	// ****************************************
	reg rst_s1_r;
	reg rst_s2_r;

	// Release through two flops so deassertion is clean
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	wire rst_b = rst_s2_r;

	// ****************************************
	// Registers
	// ****************************************
	reg  [7:0] receiver_irq_enable_one_r;
	reg  [7:0] receiver_irq_enable_two_r;
	reg  [7:0] receiver_irq_trigger_one_r;
	wire       sel_one   = (reg_addr_in == `RX_IRQ_ENABLE_ONE_ADDR);
	wire       sel_two   = (reg_addr_in == `RX_IRQ_ENABLE_TWO_ADDR);
	wire       sel_trig  = (reg_addr_in == `RX_IRQ_TRIGGER_ONE_ADDR);

	assign reg_hit_out = sel_one | sel_two | sel_trig;

	// One write strobe per register; unmapped writes match none
	wire       wr_one    = reg_wr_in & sel_one;
	wire       wr_two    = reg_wr_in & sel_two;
	wire       wr_trig   = reg_wr_in & sel_trig;

	// Writes; all enables reset masked, all mode register one fields reset to rising edge
	always @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			receiver_irq_enable_one_r  <= `RX_IRQ_ENABLE_ONE_RST;
			receiver_irq_enable_two_r  <= `RX_IRQ_ENABLE_TWO_RST;
			receiver_irq_trigger_one_r <= `RX_IRQ_TRIGGER_ONE_RST;
		end else begin
			if (wr_one) begin
				receiver_irq_enable_one_r <= reg_wdata_in;
			end
			if (wr_two) begin
				// Upper seven bits are not implemented
				receiver_irq_enable_two_r <= reg_wdata_in & `RX_IRQ_TWO_MASK;
			end
			if (wr_trig) begin
				receiver_irq_trigger_one_r <= reg_wdata_in;
			end
		end
	end

	// Read select; unmapped addresses give zero
	reg  [7:0] rd_mux;
	always @* begin
		rd_mux = 8'h00;
		if (sel_one) begin
			rd_mux = receiver_irq_enable_one_r;
		end else if (sel_two) begin
			rd_mux = receiver_irq_enable_two_r;
		end else if (sel_trig) begin
			rd_mux = receiver_irq_trigger_one_r;
		end
	end

	// Read data registered and held until the next read strobe
	always @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rd_mux;
		end
	end

	// ****************************************
	// Per-flag trigger and enable
	// ****************************************
	wire [8:0]  flag_vec;
	wire [8:0]  enable_vec;
	wire [17:0] mode_vec;
	wire [8:0]  req_vec;

	// ****************************************
	// Named enable and trigger fields
	// ****************************************
	wire       cs_crc_irq_enable;
	wire       parity_err_irq_enable;
	wire       validity_irq_enable;
	wire       biphase_err_irq_enable;
	wire       subcode_change_irq_enable;
	wire       lock_loss_irq_enable;
	wire       subcode_crc_irq_enable;
	wire       buffer_xfer_irq_enable;
	wire       out_slip_irq_enable;
	wire [1:0] subcode_change_trigger;
	wire [1:0] lock_loss_trigger;
	wire [1:0] subcode_crc_trigger;
	wire [1:0] buffer_xfer_trigger;

	// Enable register one, bit 7 down to bit 0
	assign cs_crc_irq_enable         = receiver_irq_enable_one_r[`CS_CRC_BIT];
	assign parity_err_irq_enable     = receiver_irq_enable_one_r[`PARITY_ERR_BIT];
	assign validity_irq_enable       = receiver_irq_enable_one_r[`VALIDITY_BIT];
	assign biphase_err_irq_enable    = receiver_irq_enable_one_r[`BIPHASE_ERR_BIT];
	assign subcode_change_irq_enable = receiver_irq_enable_one_r[`SUBCODE_CHANGE_BIT];
	assign lock_loss_irq_enable      = receiver_irq_enable_one_r[`LOCK_LOSS_BIT];
	assign subcode_crc_irq_enable    = receiver_irq_enable_one_r[`SUBCODE_CRC_BIT];
	assign buffer_xfer_irq_enable    = receiver_irq_enable_one_r[`BUFFER_XFER_BIT];

	// Only bit 0 of enable register two is live
	assign out_slip_irq_enable = receiver_irq_enable_two_r[`OUT_SLIP_BIT];

	// Mode register one fields, two bits each
	assign subcode_change_trigger = receiver_irq_trigger_one_r[`SUBCODE_CHANGE_TRIG_LSB +: 2];
	assign lock_loss_trigger      = receiver_irq_trigger_one_r[`LOCK_LOSS_TRIG_LSB +: 2];
	assign subcode_crc_trigger    = receiver_irq_trigger_one_r[`SUBCODE_CRC_TRIG_LSB +: 2];
	assign buffer_xfer_trigger    = receiver_irq_trigger_one_r[`BUFFER_XFER_TRIG_LSB +: 2];

	// Slot 8 is output slip; slots 7..0 follow enable register one
	assign flag_vec = {out_slip_flag_in, cs_crc_error_flag_in, parity_err_flag_in, validity_flag_in,
		biphase_error_flag_in, subcode_change_flag_in, lock_loss_flag_in, subcode_crc_flag_in,
		buffer_xfer_flag_in};
	// Enables in the same slot order
	assign enable_vec = {
		out_slip_irq_enable,
		cs_crc_irq_enable,
		parity_err_irq_enable,
		validity_irq_enable,
		biphase_err_irq_enable,
		subcode_change_irq_enable,
		lock_loss_irq_enable,
		subcode_crc_irq_enable,
		buffer_xfer_irq_enable
	};
	// Mode fields placed per flag slot; five modes come from outside
	assign mode_vec = {
		out_slip_trigger_in,
		cs_crc_trigger_in,
		parity_err_trigger_in,
		validity_trigger_in,
		biphase_err_trigger_in,
		subcode_change_trigger,
		lock_loss_trigger,
		subcode_crc_trigger,
		buffer_xfer_trigger
	};

	genvar i;
	generate
		for (i = 0; i < 9; i = i + 1) begin : g_flag
			// Status flags pass by untouched; only the request is gated
			flag_trigger u_trig (
				.clk_in    (core_clk_in),
				.rst_b_in  (rst_b),
				.flag_in   (flag_vec[i]),
				.enable_in (enable_vec[i]),
				.mode_in   (mode_vec[2*i+1:2*i]),
				.req_out   (req_vec[i])
			);
		end
	endgenerate

	// ****************************************
	// Combined interrupt
	// ****************************************
	// Any enabled request pulls the pin low
	wire irq_any = |req_vec;

	// Registered so the pin is glitch free; costs one cycle of latency
	always @(posedge core_clk_in or negedge rst_b) begin
		if (!rst_b) begin
			rx_irq_b_out <= 1'b1;
		end else begin
			rx_irq_b_out <= ~irq_any;
		end
	end

endmodule // receiver_irq_mask_mode

// ---- dv/rx_irq_chk.sv ----
// Port checker for the receiver interrupt mask and mode block.
// Assumes a bind to the top module; enables are shadowed from register writes.
`timescale 1ns/10ps
module rx_irq_chk (
	input wire       core_clk_in, rst_b_in, reg_wr_in, reg_rd_in, reg_hit_out, rx_irq_b_out,
	input wire [6:0] reg_addr_in,
	input wire [7:0] reg_wdata_in, reg_rdata_out,
	input wire       cs_crc_error_flag_in, parity_err_flag_in, validity_flag_in, out_slip_flag_in,
	input wire [1:0] cs_crc_trigger_in, parity_err_trigger_in, validity_trigger_in,
	input wire [1:0] biphase_err_trigger_in, out_slip_trigger_in
);
	reg [7:0] en_r;
	reg       sl_r;
	// Enable shadow, so each flag assertion knows whether its flag may fire
	always @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			en_r <= 8'h00;
			sl_r <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == 7'h16) en_r <= reg_wdata_in;
			if (reg_wr_in && reg_addr_in == 7'h17) sl_r <= reg_wdata_in[0];
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_hit_decode: assert property (reg_hit_out == (reg_addr_in inside {7'h16, 7'h17, 7'h18}))
		else $error("bad decode");
	a_unmapped_zero: assert property (reg_rd_in && !reg_hit_out |=> reg_rdata_out == 8'h00)
		else $error("unmapped read");
	a_masked_quiet: assert property ((en_r == 8'h00 && !sl_r) [*2] |=> rx_irq_b_out)
		else $error("masked irq");
	a_crc_rise: assert property (en_r[7] && cs_crc_trigger_in == 2'h0 && $rose(cs_crc_error_flag_in)
		|-> ##[1:2] !rx_irq_b_out) else $error("no rise irq");
	a_parity_fall: assert property (en_r[6] && parity_err_trigger_in == 2'h1 && $fell(parity_err_flag_in)
		|-> ##[1:2] !rx_irq_b_out) else $error("no fall irq");
	a_valid_level: assert property ((en_r[5] && validity_trigger_in == 2'h2 && validity_flag_in) [*3]
		|-> !rx_irq_b_out) else $error("no level irq");
	a_rsvd_quiet: assert property ((en_r == 8'h10 && !sl_r && biphase_err_trigger_in == 2'h3) [*3]
		|-> rx_irq_b_out) else $error("reserved mode irq");
	a_slip_level: assert property ((sl_r && out_slip_trigger_in == 2'h2 && out_slip_flag_in) [*3]
		|-> !rx_irq_b_out) else $error("no slip irq");
endmodule // rx_irq_chk

// ---- dv/tb.sv ----
// Self-checking bench of the receiver interrupt mask and mode block.
// Assumes the design and the checker are compiled first.
`timescale 1ns/10ps
module tb;
	logic       core_clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic [6:0] reg_addr_in = 7'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [8:0] fl = 9'h000;
	logic [9:0] trg = 10'h000;
	wire  [7:0] reg_rdata_out;
	wire        reg_hit_out, rx_irq_b_out;
	int         fails = 0, n_tests = 0;
	logic [7:0] exp_t [5] = '{8'h01, 8'h01, 8'hff, 8'h00, 8'h00};

	receiver_irq_mask_mode uut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.reg_hit_out(reg_hit_out), .cs_crc_error_flag_in(fl[7]), .parity_err_flag_in(fl[6]),
		.validity_flag_in(fl[5]), .biphase_error_flag_in(fl[4]), .subcode_change_flag_in(fl[3]),
		.lock_loss_flag_in(fl[2]), .subcode_crc_flag_in(fl[1]), .buffer_xfer_flag_in(fl[0]),
		.out_slip_flag_in(fl[8]), .cs_crc_trigger_in(trg[9:8]), .parity_err_trigger_in(trg[7:6]),
		.validity_trigger_in(trg[5:4]), .biphase_err_trigger_in(trg[3:2]), .out_slip_trigger_in(trg[1:0]),
		.rx_irq_b_out(rx_irq_b_out));

	always #10 core_clk_in = ~core_clk_in;

	task check(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Strobes held one full cycle, driven on the falling edge
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
		@(negedge core_clk_in) reg_wr_in = 1'b0;
	endtask
	task rd(input logic [6:0] a, input logic [7:0] e);
		@(negedge core_clk_in) {reg_addr_in, reg_rd_in} = {a, 1'b1};
		@(negedge core_clk_in) reg_rd_in = 1'b0;
		check("read data", reg_rdata_out, e);
		check("decode hit", {7'h00, reg_hit_out}, {7'h00, (a == 7'h16 || a == 7'h17 || a == 7'h18)});
	endtask
	task t_regs;
		rd(7'h16, 8'h00);
		rd(7'h17, 8'h00);
		rd(7'h18, 8'h00);
		wr(7'h15, 8'h55);
		rd(7'h15, 8'h00);
		wr(7'h16, 8'ha5);
		rd(7'h16, 8'ha5);
		wr(7'h17, 8'hff);
		rd(7'h17, 8'h01);
		wr(7'h18, 8'h9c);
		rd(7'h18, 8'h9c);
		$display("register test done");
	endtask
	// Every flag in every mode; m of 4 is level mode with the flag masked
	task t_modes;
		int c;
		logic [1:0] md;
		for (int i = 0; i < 9; i++)
			for (int m = 0; m < 5; m++) begin
				md = (m == 4) ? 2'h2 : 2'(m);
				wr(7'h16, (m < 4 && i < 8) ? 8'h01 << i : 8'h00);
				wr(7'h17, {7'h00, m < 4 && i == 8});
				wr(7'h18, (i < 4) ? {6'h00, md} << 2 * i : 8'h00);
				trg = (i < 4) ? 10'h000 : {8'h00, md} << ((i == 8) ? 0 : 2 * (i - 3));
				c = 0;
				@(negedge core_clk_in) fl[i] = 1'b1;
				for (int k = 0; k < 10; k++) begin
					@(negedge core_clk_in) c += (rx_irq_b_out === 1'b0);
					if (k == 3) fl[i] = 1'b0;
				end
				check("irq low cycles", (c > 3) ? 8'hff : 8'(c), exp_t[m]);
			end
		$display("mode test done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge core_clk_in);
		t_regs;
		t_modes;
		complete_run;
	end
	// Watchdog, several times the expected run length
	initial begin
		#100000;
		fails++;
		complete_run;
	end
endmodule // tb

bind receiver_irq_mask_mode rx_irq_chk chk (.*);
